/* File: logic/pwm_generator_deadband_unit.sv */
`timescale 1ns/1ps

// Summary of operation
// - count-down mode counts load to zero, reloads, repeats.
// - up/down mode counts zero to load and back, repeatedly.
// - direction low in down mode; low rising, high falling in up/down.
// - one-cycle pulses at zero and at load; load follows zero in down.
// - comparator pulses on match, split up/down by direction.
// - match value above load value never matches.
// - four events act in down mode, six in up/down mode.
// - match events coinciding with zero or load are ignored.
// - on coincident matches, output A uses A only, output B uses B.
// - per event and output: nothing, toggle, low or high.
// - dead-band disabled passes both signals unchanged.
// - dead-band enabled drops B; first output is A rising-delayed.
// - second output is inverted A, rising delayed after A falls.
// - selected events raise the generator interrupt.
// - separately selected events emit an ADC trigger pulse.
// - interrupt and trigger use raw events, not dead-band edges.
// - global reset command returns counter to zero.
// - immediate mode applies new values at next counter zero.
// - sync mode holds new values until global update, then at zero.
// - fault forces outputs with fault bit inactive; may interrupt.
// - stall either runs to zero and stops, or keeps counting; no irq.
// - per-output enable and inversion at the pins.
module pwm_generator_deadband_unit
  import pwm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic gen_enable,
  input wire count_mode_t count_mode,
  input wire logic sync_update_mode,
  input wire logic [CNT_W-1:0] load_value,
  input wire logic [CNT_W-1:0] cmp_a_value,
  input wire logic [CNT_W-1:0] cmp_b_value,
  input wire logic value_write,
  input wire logic global_update,
  input wire logic counter_sync,
  input wire logic [2*NUM_EVT-1:0] act_a,
  input wire logic [2*NUM_EVT-1:0] act_b,
  input wire logic db_enable,
  input wire logic [CNT_W-1:0] db_rise,
  input wire logic [CNT_W-1:0] db_fall,
  input wire logic [NUM_EVT-1:0] int_select,
  input wire logic [NUM_EVT-1:0] trig_select,
  input wire logic fault_in,
  input wire logic fault_int_enable,
  input wire logic debug_stall,
  input wire logic stall_stop_at_zero,
  input wire logic [NUM_OUT-1:0] out_enable,
  input wire logic [NUM_OUT-1:0] out_invert,
  input wire logic [NUM_OUT-1:0] out_fault_en,
  output logic first_pwm_output,
  output logic second_pwm_output,
  output logic gen_interrupt,
  output logic fault_interrupt,
  output logic adc_trigger,
  output logic direction,
  output logic [CNT_W-1:0] count_value,
  output logic update_pending
);

  // ----------------------------------------
  // fault pin synchroniser
  // ----------------------------------------
  logic fault_s1_reg;
  logic fault_s2_reg;
  logic fault_s3_reg;
  logic fault_reg;
  wire logic fault_next = (fault_s2_reg == fault_s3_reg) ? fault_s3_reg : fault_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fault_s1_reg <= 1'b0;
      fault_s2_reg <= 1'b0;
      fault_s3_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      fault_s1_reg <= fault_in;
      fault_s2_reg <= fault_s1_reg;
      fault_s3_reg <= fault_s2_reg;
      fault_reg <= fault_next;
    end
  end

  // ----------------------------------------
  // shadowed load and compare values
  // ----------------------------------------
  logic [CNT_W-1:0] load_reg;
  logic [CNT_W-1:0] cmpa_reg;
  logic [CNT_W-1:0] cmpb_reg;
  logic [CNT_W-1:0] load_pend_reg;
  logic [CNT_W-1:0] cmpa_pend_reg;
  logic [CNT_W-1:0] cmpb_pend_reg;
  logic pend_reg;
  logic armed_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic dir_reg;
  logic dir_next;
  logic stopped_reg;

  wire logic at_zero = (cnt_reg == CNT_RESET);
  wire logic at_load = (cnt_reg == load_reg);
  // a write in the zero cycle still waits for the next zero
  wire logic apply_now = at_zero && pend_reg && !value_write &&
                         (!sync_update_mode || armed_reg);
  wire logic pend_next = value_write | (pend_reg & ~apply_now);
  // arm set wins over the clear on apply
  wire logic armed_next = (sync_update_mode & global_update) | (armed_reg & ~apply_now);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      load_pend_reg <= LOAD_RESET;
      cmpa_pend_reg <= CMP_RESET;
      cmpb_pend_reg <= CMP_RESET;
      pend_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      if (value_write) begin
        load_pend_reg <= load_value;
        cmpa_pend_reg <= cmp_a_value;
        cmpb_pend_reg <= cmp_b_value;
      end
      pend_reg <= pend_next;
      armed_reg <= armed_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      load_reg <= LOAD_RESET;
      cmpa_reg <= CMP_RESET;
      cmpb_reg <= CMP_RESET;
    end else if (apply_now) begin
      load_reg <= load_pend_reg;
      cmpa_reg <= cmpa_pend_reg;
      cmpb_reg <= cmpb_pend_reg;
    end
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  wire logic up_dn = (count_mode == MODE_UPDOWN);
  // stall with stop-at-zero holds once zero is reached
  wire logic hold = !gen_enable || (debug_stall && stall_stop_at_zero && at_zero);
  // zero cycle reloads from the values being applied, so no stale period follows
  wire logic [CNT_W-1:0] load_now = apply_now ? load_pend_reg : load_reg;
  // top reached or passed; a zero load parks the counter at zero
  wire logic at_top = (cnt_reg >= load_now);
  wire logic [CNT_W-1:0] cnt_down = at_zero ? load_now : cnt_reg - CNT_ONE;
  wire logic turn_dn = up_dn && !at_zero && (at_top || dir_reg);
  wire logic [CNT_W-1:0] cnt_ud = turn_dn ? cnt_reg - CNT_ONE :
                                  (at_top ? cnt_reg : cnt_reg + CNT_ONE);

  assign cnt_next = counter_sync ? CNT_RESET :
                    (hold ? cnt_reg : (up_dn ? cnt_ud : cnt_down));
  // a held counter keeps its direction, but never high in down mode
  assign dir_next = counter_sync ? 1'b0 : (hold ? dir_reg && up_dn : turn_dn);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= CNT_RESET;
      dir_reg <= 1'b0;
      stopped_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      dir_reg <= dir_next;
      stopped_reg <= hold;
    end
  end

  // ----------------------------------------
  // events
  // ----------------------------------------
  // a held counter would repeat pulses, so only a fresh count qualifies
  wire logic live = !stopped_reg;
  wire logic ev_zero = live && at_zero;
  wire logic ev_load = live && at_load;
  wire logic boundary = ev_zero || ev_load;
  wire logic match_a = live && (cnt_reg == cmpa_reg) && (cmpa_reg <= load_reg);
  wire logic match_b = live && (cnt_reg == cmpb_reg) && (cmpb_reg <= load_reg);
  wire logic dn_phase = !up_dn || dir_reg;
  logic [NUM_EVT-1:0] events;

  assign events[EV_ZERO] = ev_zero;
  assign events[EV_LOAD] = ev_load;
  assign events[EV_A_UP] = match_a && !boundary && up_dn && !dn_phase;
  assign events[EV_A_DN] = match_a && !boundary && dn_phase;
  assign events[EV_B_UP] = match_b && !boundary && up_dn && !dn_phase;
  assign events[EV_B_DN] = match_b && !boundary && dn_phase;

  // ----------------------------------------
  // signal generator
  // ----------------------------------------
  function automatic logic apply_act(input logic cur, input logic [1:0] act);
    unique case (act)
      ACT_NONE: apply_act = cur;
      ACT_TOGGLE: apply_act = ~cur;
      ACT_LOW: apply_act = 1'b0;
      ACT_HIGH: apply_act = 1'b1;
    endcase
  endfunction

  // output A ignores B matches and vice versa
  function automatic logic gen_next(input logic cur, input logic [2*NUM_EVT-1:0] act,
                                    input logic [NUM_EVT-1:0] ev, input logic use_a);
    logic v;
    v = cur;
    if (ev[EV_ZERO]) v = apply_act(v, act[2*EV_ZERO +: 2]);
    if (ev[EV_LOAD]) v = apply_act(v, act[2*EV_LOAD +: 2]);
    if (use_a && ev[EV_A_UP]) v = apply_act(v, act[2*EV_A_UP +: 2]);
    if (use_a && ev[EV_A_DN]) v = apply_act(v, act[2*EV_A_DN +: 2]);
    if (!use_a && ev[EV_B_UP]) v = apply_act(v, act[2*EV_B_UP +: 2]);
    if (!use_a && ev[EV_B_DN]) v = apply_act(v, act[2*EV_B_DN +: 2]);
    gen_next = v;
  endfunction

  logic gen_a_reg;
  logic gen_b_reg;
  wire logic gen_a_next = gen_next(gen_a_reg, act_a, events, 1'b1);
  wire logic gen_b_next = gen_next(gen_b_reg, act_b, events, 1'b0);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gen_a_reg <= 1'b0;
      gen_b_reg <= 1'b0;
    end else begin
      gen_a_reg <= gen_a_next;
      gen_b_reg <= gen_b_next;
    end
  end

  // ----------------------------------------
  // dead-band
  // ----------------------------------------
  logic db_a;
  logic db_b;

  deadband_delay u_rise (
    .clk(clk),
    .rst_n(rst_n),
    .sig_in(gen_a_reg),
    .delay(db_rise),
    .sig_out(db_a)
  );

  deadband_delay u_fall (
    .clk(clk),
    .rst_n(rst_n),
    .sig_in(~gen_a_reg),
    .delay(db_fall),
    .sig_out(db_b)
  );

  // bypass path delayed one cycle to match the delay stage latency
  logic pass_a_reg;
  logic pass_b_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pass_a_reg <= 1'b0;
      pass_b_reg <= 1'b0;
    end else begin
      pass_a_reg <= gen_a_reg;
      pass_b_reg <= gen_b_reg;
    end
  end

  wire logic sel_a = db_enable ? db_a : pass_a_reg;
  wire logic sel_b = db_enable ? db_b : pass_b_reg;

  // ----------------------------------------
  // output control
  // ----------------------------------------
  wire logic [NUM_OUT-1:0] raw = {sel_b, sel_a};
  wire logic [NUM_OUT-1:0] forced = out_fault_en & {NUM_OUT{fault_reg}};
  wire logic [NUM_OUT-1:0] active = raw & out_enable & ~forced;
  wire logic [NUM_OUT-1:0] pins_next = active ^ out_invert;
  logic [NUM_OUT-1:0] pins_reg;

  // ----------------------------------------
  // interrupt and trigger selection
  // ----------------------------------------
  // raw events only; stall is not an event source
  wire logic int_next = |(events & int_select);
  wire logic trig_next = |(events & trig_select);
  logic int_reg;
  logic trig_reg;
  logic fint_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pins_reg <= 2'h0;
      int_reg <= 1'b0;
      trig_reg <= 1'b0;
      fint_reg <= 1'b0;
    end else begin
      pins_reg <= pins_next;
      int_reg <= int_next;
      trig_reg <= trig_next;
      fint_reg <= fault_reg & fault_int_enable;
    end
  end

  assign first_pwm_output = pins_reg[0];
  assign second_pwm_output = pins_reg[1];
  assign gen_interrupt = int_reg;
  assign adc_trigger = trig_reg;
  assign fault_interrupt = fint_reg;
  assign direction = dir_reg;
  assign count_value = cnt_reg;
  assign update_pending = pend_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_load_follows_zero: assert property (@(posedge clk) disable iff (!rst_n)
    ev_zero && !up_dn && !hold && !counter_sync && gen_enable ##1 !up_dn && live
      |-> ev_load) else $error("load pulse did not follow zero");
  a_down_dir_low: assert property (@(posedge clk) disable iff (!rst_n)
    !up_dn && $stable(count_mode) |=> !dir_reg || $changed(count_mode)) else
      $error("direction high in down mode");
  a_match_guard: assert property (@(posedge clk) disable iff (!rst_n)
    cmpa_reg > load_reg |-> !events[EV_A_UP] && !events[EV_A_DN]) else
      $error("match above load");
  a_boundary_mask: assert property (@(posedge clk) disable iff (!rst_n)
    boundary |-> events[5:2] == 4'h0) else $error("match during boundary");
  a_sync_reset: assert property (@(posedge clk) disable iff (!rst_n)
    counter_sync |=> cnt_reg == CNT_RESET) else $error("sync did not clear counter");
  a_apply_zero: assert property (@(posedge clk) disable iff (!rst_n)
    load_reg != $past(load_reg) |-> $past(at_zero)) else $error("load changed mid period");
  a_sync_hold: assert property (@(posedge clk) disable iff (!rst_n)
    sync_update_mode && !armed_reg |=> {load_reg, cmpa_reg, cmpb_reg} ==
      $past({load_reg, cmpa_reg, cmpb_reg})) else $error("applied without update");
  a_fault_force: assert property (@(posedge clk) disable iff (!rst_n)
    fault_reg && out_fault_en[0] && $stable(out_invert[0]) |=>
      first_pwm_output == $past(out_invert[0])) else $error("fault did not force output");
  a_trig_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    trig_next |=> adc_trigger) else $error("trigger missing");
  c_down_cycle: cover property (@(posedge clk) !up_dn && ev_zero ##1 ev_load);
  c_updown_turn: cover property (@(posedge clk) up_dn && ev_load ##1 dir_reg);
  c_sync_apply: cover property (@(posedge clk) sync_update_mode && apply_now);
  c_fault: cover property (@(posedge clk) fault_reg && out_fault_en != 2'h0);

endmodule // pwm_generator_deadband_unit

/* File: logic/pwm_pkg.sv */
package pwm_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int CNT_W = 16;
  localparam int NUM_OUT = 2;
  localparam int NUM_EVT = 6;

  // ----------------------------------------
  // event vector positions
  // ----------------------------------------
  localparam int EV_ZERO = 0;
  localparam int EV_LOAD = 1;
  localparam int EV_A_UP = 2;
  localparam int EV_A_DN = 3;
  localparam int EV_B_UP = 4;
  localparam int EV_B_DN = 5;

  // ----------------------------------------
  // action codes, two bits per event
  // ----------------------------------------
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_LOW = 2'h2;
  localparam logic [1:0] ACT_HIGH = 2'h3;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] LOAD_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CMP_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  typedef enum logic {MODE_DOWN, MODE_UPDOWN} count_mode_t;

endpackage

/* File: logic/deadband_delay.sv */
`timescale 1ns/1ps

// ----------------------------------------
// rising-edge delay of one signal
// ----------------------------------------
module deadband_delay
  import pwm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sig_in,
  input wire logic [CNT_W-1:0] delay,
  output logic sig_out
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic out_reg;
  logic out_next;
  wire logic done = (cnt_reg >= delay);

  // counter restarts on each low level, so a short high pulse is swallowed
  assign cnt_next = !sig_in ? CNT_RESET : (done ? cnt_reg : cnt_reg + CNT_ONE);
  assign out_next = sig_in && (done || delay == CNT_RESET);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= CNT_RESET;
      out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign sig_out = out_reg;

endmodule // deadband_delay

/* File: verification/bridge_driver_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// half-bridge gate stage
// ----------------------------------------
module bridge_driver_model (
  input wire logic clk,
  input wire logic armed,
  input wire logic high_gate,
  input wire logic low_gate,
  output int shoot_count
);
  initial shoot_count = 0;
  // both switches on shorts the rail; only a paired drive must avoid it
  always @(posedge clk) begin
    if (armed === 1'b1 && high_gate === 1'b1 && low_gate === 1'b1) begin
      shoot_count <= shoot_count + 1;
    end
  end
endmodule // bridge_driver_model

/* File: verification/pwm_generator_deadband_unit_tb.sv */
`timescale 1ns/1ps

module pwm_generator_deadband_unit_tb;
  import pwm_pkg::*;
  // ----------------------------------------
  // stimulus and observation
  // ----------------------------------------
  logic clk, rst_n, gen_enable, sync_update_mode, value_write, global_update, counter_sync;
  count_mode_t mode;
  logic [CNT_W-1:0] load_v, cmp_a_v, cmp_b_v, db_rise, db_fall, count_value, pk, c;
  logic [11:0] act_a, act_b;
  logic [5:0] trig_sel;
  logic db_enable, fault_in, fault_int_enable, debug_stall, stall_stop_at_zero;
  logic [1:0] out_enable, out_invert, out_fault_en;
  logic first_o, second_o, gen_int, fault_int, adc_trig, direction, update_pending;
  logic [17:0] notes[$];
  logic [17:0] n;
  logic [16:0] prev;
  logic [31:0] seed;
  int bad_count, checks, shoot, h1, h2;
  // care bit, direction, count of each raw event
  logic [17:0] ev_note [6] = '{18'h00000, 18'h00008, 18'h20003, 18'h30003, 18'h20005, 18'h30005};
  logic [15:0] nm [2] = '{16'h0000, 16'h0008};

  pwm_generator_deadband_unit u_pwm_generator_deadband_unit (.clk(clk), .rst_n(rst_n),
    .gen_enable(gen_enable), .count_mode(mode), .sync_update_mode(sync_update_mode),
    .load_value(load_v), .cmp_a_value(cmp_a_v), .cmp_b_value(cmp_b_v),
    .value_write(value_write), .global_update(global_update), .counter_sync(counter_sync),
    .act_a(act_a), .act_b(act_b), .db_enable(db_enable), .db_rise(db_rise),
    .db_fall(db_fall), .int_select(trig_sel), .trig_select(trig_sel), .fault_in(fault_in),
    .fault_int_enable(fault_int_enable), .debug_stall(debug_stall),
    .stall_stop_at_zero(stall_stop_at_zero), .out_enable(out_enable),
    .out_invert(out_invert), .out_fault_en(out_fault_en), .first_pwm_output(first_o),
    .second_pwm_output(second_o), .gen_interrupt(gen_int), .fault_interrupt(fault_int),
    .adc_trigger(adc_trig), .direction(direction), .count_value(count_value),
    .update_pending(update_pending));

  bridge_driver_model u_bridge_driver_model (.clk(clk), .armed(db_enable),
    .high_gate(first_o), .low_gate(second_o), .shoot_count(shoot));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic wr();
    value_write = 1'b1;
    cyc(1);
    value_write = 1'b0;
  endtask

  task automatic restart(input count_mode_t m, input logic [15:0] ld, a, b);
    rst_n = 1'b0;
    gen_enable = 1'b0;
    mode = m;
    load_v = ld;
    cmp_a_v = a;
    cmp_b_v = b;
    cyc(12);
    rst_n = 1'b1;
    wr();
    gen_enable = 1'b1;
    cyc(40);
  endtask

  task automatic wait_count(input logic [15:0] v);
    for (int i = 0; i < 100 && count_value !== v; i++) cyc(1);
  endtask

  // waits until every noted pulse has been seen, then stops selecting
  task automatic drain();
    for (int i = 0; i < 60 && notes.size() != 0; i++) cyc(1);
    trig_sel = 6'h00;
    cyc(1);
    check(notes.size(), 0, "missing event");
  endtask

  task automatic measure(input int k);
    cyc(4);
    h1 = 0;
    h2 = 0;
    pk = 16'h0000;
    repeat (k) begin
      cyc(1);
      h1 += int'(first_o);
      h2 += int'(second_o);
      if (count_value > pk) pk = count_value;
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // monitor: pulses against noted events
  // ----------------------------------------
  always @(negedge clk) begin
    if (rst_n === 1'b1) begin
      check(gen_int, adc_trig, "irq vs trigger");
      if (adc_trig === 1'b1 && notes.size() == 0) begin
        bad_count++;
        $display("[FAIL] %0t unexpected trigger", $time);
      end else if (adc_trig === 1'b1) begin
        n = notes.pop_front();
        check({15'h0000, n[17] & prev[16], prev[15:0]},
              {15'h0000, n[17] & n[16], n[15:0]}, "event");
      end
    end
    prev = {direction, count_value};
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("[FAIL] %0t watchdog", $time);
    conclude();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    bad_count = 0;
    checks = 0;
    seed = 32'h00000001;
    {sync_update_mode, global_update, counter_sync, value_write, db_enable} = 5'h00;
    {fault_in, fault_int_enable, debug_stall, stall_stop_at_zero} = 4'h0;
    db_rise = 16'h0000;
    db_fall = 16'h0000;
    trig_sel = 6'h00;
    out_enable = 2'h3;
    out_invert = 2'h0;
    out_fault_en = 2'h0;
    act_a = {ACT_HIGH, ACT_NONE, ACT_LOW, ACT_NONE, ACT_NONE, ACT_HIGH};
    act_b = {ACT_HIGH, ACT_NONE, ACT_LOW, ACT_NONE, ACT_NONE, ACT_LOW};
    restart(MODE_UPDOWN, 16'h0008, 16'h0003, 16'h0005);
    for (int e = 0; e < NUM_EVT; e++) begin
      notes.push_back(ev_note[e]);
      trig_sel = 6'h01 << e;
      drain();
    end
    foreach (nm[i]) begin
      restart(MODE_UPDOWN, 16'h0008, nm[i], 16'h0009);
      trig_sel = 6'h3C;
      cyc(40);
      trig_sel = 6'h00;
    end
    restart(MODE_DOWN, 16'h0008, 16'h0003, 16'h0003);
    wait_count(16'h0002);
    notes.push_back(18'h20000);
    notes.push_back(18'h20008);
    trig_sel = 6'h03;
    drain();
    measure(9);
    check(h1, 6, "first duty");
    check(h2, 3, "second duty");
    out_invert = 2'h1;
    measure(9);
    check(h1, 3, "inverted");
    out_invert = 2'h0;
    out_enable = 2'h2;
    measure(9);
    check(h1 * 16 + h2, 3, "enable mask");
    out_enable = 2'h3;
    seed = next_rand(seed);
    db_rise = {14'h0000, seed[1:0]};
    db_fall = {15'h0000, seed[2]};
    db_enable = 1'b1;
    cyc(30);
    measure(9);
    check(h1, 32'h00000006 - db_rise, "rise delay");
    check(h2, 32'h00000003 - db_fall, "fall delay");
    check(shoot, 0, "overlap");
    db_enable = 1'b0;
    out_fault_en = 2'h1;
    fault_int_enable = 1'b1;
    fault_in = 1'b1;
    cyc(8);
    measure(9);
    check({h1[30:0], fault_int}, {31'h00000000, 1'b1}, "fault forcing");
    fault_in = 1'b0;
    cyc(8);
    check(fault_int, 1'b0, "fault clear");
    act_a = {10'h000, ACT_TOGGLE};
    cyc(20);
    measure(18);
    check(h1, 9, "toggle");
    wait_count(16'h0005);
    load_v = 16'h0006;
    wr();
    check(count_value, 16'h0004, "mid period");
    cyc(12);
    measure(14);
    check(pk, 16'h0006, "new load");
    sync_update_mode = 1'b1;
    load_v = 16'h0004;
    wr();
    measure(20);
    check({update_pending, pk}, {1'b1, 16'h0006}, "held load");
    global_update = 1'b1;
    cyc(1);
    global_update = 1'b0;
    cyc(20);
    measure(10);
    check({update_pending, pk}, {1'b0, 16'h0004}, "armed load");
    sync_update_mode = 1'b0;
    wait_count(16'h0003);
    counter_sync = 1'b1;
    cyc(1);
    counter_sync = 1'b0;
    check(count_value, 16'h0000, "counter sync");
    debug_stall = 1'b1;
    stall_stop_at_zero = 1'b1;
    cyc(20);
    check(count_value, 16'h0000, "stall stop");
    stall_stop_at_zero = 1'b0;
    cyc(2);
    c = count_value;
    cyc(1);
    check(count_value !== c, 1'b1, "stall run");
    debug_stall = 1'b0;
    conclude();
  end
endmodule // pwm_generator_deadband_unit_tb
